// ===== inc/fsp_pkg.sv
// constants, operation codes and burst helpers for the flow-through sync memory port
// assumes one clock; all pins but reset and output enable sampled synchronously to it
package fsp_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W   = 21;
    localparam int DATA_W   = 48;
    localparam int LANES    = 6;
    localparam int LANE_W   = 8;
    localparam int BURST_W  = 2;
    localparam int WORDS    = 2097152;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0]  RST_ADDR  = 21'h00_0000;
    localparam logic [BURST_W-1:0] RST_CNT   = 2'h0;
    localparam logic [DATA_W-1:0]  RST_DATA  = 48'h0000_0000_0000;
    localparam logic [LANES-1:0]   RST_LANES = 6'h00;

    // ------------------------------------------------------------
    // operation in flight
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSP_IDLE  = 3'h1,
        FSP_READ  = 3'h2,
        FSP_WRITE = 3'h4
    } fsp_op_e;

    // linear adds the count, interleaved xors it; both stay in the group of four
    function automatic logic [BURST_W-1:0] fsp_burst(input logic [BURST_W-1:0] base,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic               ilv);
        fsp_burst = ilv ? (base ^ cnt) : BURST_W'(base + cnt);
    endfunction

endpackage

// ===== verilog/fsp_sram_port.sv
// flow-through synchronous static memory, 2M words of 48 bits, no turnaround wait states
// assumes the controller keeps its own rules; data pin is split into in, out and enable
`timescale 1ns/100ps

// Operation
// - store 2M x 48, 21-bit address
// - capture inputs only while qualifier low
// - qualifier high freezes state, no deselect
// - writes complete internally, self timed
// - drivers off during write data phase
// - select when a low, high high, b low
// - low two address bits seed burst counter
// - four-word bursts, linear or interleaved
// - per-lane write enables, masked lanes kept
// - output enable plus logic gates drivers
// - back-to-back reads and writes, no waits
// - advance high steps, low loads address
// - read drives word of previous edge address
// - drivers off deselected and first cycle after
module fsp_sram_port
    import fsp_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               clk_en,
    // command pins
    input  wire logic               clock_qualify_n,
    input  wire logic               select_low_a_n,
    input  wire logic               select_high,
    input  wire logic               select_low_b_n,
    input  wire logic               write_n,
    input  wire logic [LANES-1:0]   byte_lane_write_n,
    input  wire logic               advance_or_load,
    input  wire logic               burst_interleave,
    input  wire logic [ADDR_W-1:0]  addr,
    input  wire logic               out_enable_n,
    // data pins
    input  wire logic [DATA_W-1:0]  dq_in,
    output logic      [DATA_W-1:0]  dq_out,
    output logic                    dq_oe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0]  mem [0:WORDS-1];
    fsp_op_e            op_q;
    fsp_op_e            op_d;
    logic               first_q;
    logic               ilv_q;
    logic [ADDR_W-1:0]  base_q;
    logic [BURST_W-1:0] cnt_q;
    logic [BURST_W-1:0] cnt_d;
    logic [ADDR_W-1:0]  addr_d;
    logic               wr_pend_q;
    logic [ADDR_W-1:0]  wr_addr_q;
    logic [LANES-1:0]   wr_lane_q;
    logic [DATA_W-1:0]  dq_out_q;
    logic [DATA_W-1:0]  rd_word;
    logic               take;
    logic               selected;
    logic               ilv_d;

    assign take     = clk_en & ~clock_qualify_n;
    assign selected = ~select_low_a_n & select_high & ~select_low_b_n;

    // ------------------------------------------------------------
    // command and burst decode
    // ------------------------------------------------------------
    always_comb begin
        op_d   = op_q;
        cnt_d  = BURST_W'(cnt_q + 2'h1);
        ilv_d  = ilv_q;
        addr_d = {base_q[ADDR_W-1:BURST_W], fsp_burst(base_q[BURST_W-1:0], cnt_d, ilv_q)};
        if (!advance_or_load) begin
            cnt_d  = RST_CNT;
            ilv_d  = burst_interleave;
            addr_d = addr;
            if (!selected) begin
                op_d = FSP_IDLE;
            end else if (!write_n) begin
                op_d = FSP_WRITE;
            end else begin
                op_d = FSP_READ;
            end
        end
    end

    // ------------------------------------------------------------
    // operation tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op_q    <= FSP_IDLE;
            first_q <= 1'b1;
            ilv_q   <= 1'b0;
            base_q  <= RST_ADDR;
            cnt_q   <= RST_CNT;
        end else if (take) begin
            op_q    <= op_d;
            // first data cycle after a deselect is never driven
            first_q <= (op_q == FSP_IDLE);
            ilv_q   <= ilv_d;
            cnt_q   <= cnt_d;
            if (!advance_or_load) begin
                base_q <= addr;
            end
        end
    end

    // ------------------------------------------------------------
    // write path: data arrives one edge after the command
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= RST_ADDR;
            wr_lane_q <= RST_LANES;
        end else if (take) begin
            wr_pend_q <= (op_d == FSP_WRITE);
            wr_addr_q <= addr_d;
            wr_lane_q <= ~byte_lane_write_n;
        end
    end

    // array has no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (take && wr_pend_q) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lane_q[l]) begin
                    mem[wr_addr_q][l*LANE_W +: LANE_W] <= dq_in[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read path with bypass of the write landing on the same edge
    // ------------------------------------------------------------
    always_comb begin
        rd_word = mem[addr_d];
        if (wr_pend_q && (wr_addr_q == addr_d)) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lane_q[l]) begin
                    rd_word[l*LANE_W +: LANE_W] = dq_in[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_out_q <= RST_DATA;
        end else if (take && (op_d == FSP_READ)) begin
            dq_out_q <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    assign dq_out = dq_out_q;
    // output enable is asynchronous, so it stays outside any flop
    assign dq_oe  = ~out_enable_n & (op_q == FSP_READ) & ~first_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_load_sel;
        take && !advance_or_load && selected;
    endsequence

    sequence s_step;
        take && advance_or_load && (op_q != FSP_IDLE);
    endsequence

    chk_desel_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (op_q == FSP_IDLE) |-> !dq_oe)
        else $error("data driven while deselected");

    chk_write_float: assert property (@(posedge clk) disable iff (!rst_b)
        wr_pend_q |-> !dq_oe)
        else $error("data driven in write data phase");

    chk_freeze_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !take |=> $stable(op_q) && $stable(cnt_q) && $stable(base_q) && $stable(dq_out_q))
        else $error("state moved while clock qualified off");

    chk_select_decode: assert property (@(posedge clk) disable iff (!rst_b)
        (take && !advance_or_load && !selected) |=> (op_q == FSP_IDLE))
        else $error("unselected load did not deselect");

    chk_burst_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        s_step |=> $stable(base_q) && (cnt_q == BURST_W'($past(cnt_q) + 2'h1)))
        else $error("burst step wrong");

    chk_read_drive: assert property (@(posedge clk) disable iff (!rst_b)
        (s_load_sel ##0 write_n ##0 (op_q == FSP_READ) && !first_q) ##1 !out_enable_n |-> dq_oe)
        else $error("read not driven with output enabled");

    chk_no_wait: assert property (@(posedge clk) disable iff (!rst_b)
        s_load_sel |=> (op_q != FSP_IDLE) && (wr_pend_q == (op_q == FSP_WRITE)))
        else $error("selected command did not start");

    chk_first_mask: assert property (@(posedge clk) disable iff (!rst_b)
        ((op_q == FSP_IDLE) ##0 s_load_sel) |=> first_q && !dq_oe)
        else $error("first cycle after deselect driven");

    chk_load_addr: assert property (@(posedge clk) disable iff (!rst_b)
        (take && !advance_or_load) |=> (cnt_q == RST_CNT) && (base_q == $past(addr)))
        else $error("address load wrong");

    chk_write_start: assert property (@(posedge clk) disable iff (!rst_b)
        (s_load_sel ##0 !write_n) |=> wr_pend_q && (wr_addr_q == $past(addr)))
        else $error("write command not captured");

    chk_order_load: assert property (@(posedge clk) disable iff (!rst_b)
        (take && !advance_or_load) |=> (ilv_q == $past(burst_interleave)))
        else $error("burst order not loaded");

endmodule

// ===== sim/fsp_ctrl_model.sv
// controller model driving the memory port command and data pins
// assumes one beat or hold call per clock from the bench
`timescale 1ns/100ps
module fsp_ctrl_model
    import fsp_pkg::*;
(
    // clock
    input  wire logic              clk,
    // command pins, select as {low_a_n, high, low_b_n}
    output logic                   clock_qualify_n,
    output logic                   clk_en,
    output logic [2:0]             sel,
    output logic                   write_n,
    output logic [LANES-1:0]       byte_lane_write_n,
    output logic                   advance_or_load,
    output logic                   burst_interleave,
    output logic [ADDR_W-1:0]      addr,
    output logic                   out_enable_n,
    // data pin
    output logic [DATA_W-1:0]      dq_in
);
    logic              wr_q;
    logic              drv_q;
    logic [DATA_W-1:0] d_q;

    // released bus shows the inverse of the last data, never a held value
    assign dq_in = drv_q ? d_q : ~d_q;

    initial begin
        {clock_qualify_n, clk_en, sel, write_n, advance_or_load, burst_interleave} = 8'h74;
        {byte_lane_write_n, addr, out_enable_n, d_q, drv_q, wr_q} = '0;
    end

    // write data goes on the bus in the beat after its command
    task automatic beat(input logic [2:0] s, input logic wn, input logic [LANES-1:0] bl,
                        input logic adv, input logic ilv, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
        @(posedge clk);
        clock_qualify_n   <= 1'b0;
        clk_en            <= 1'b1;
        {sel, write_n, byte_lane_write_n, advance_or_load, burst_interleave, addr} <= {s, wn, bl, adv, ilv, a};
        d_q               <= d;
        drv_q             <= wr_q;
        wr_q              <= adv ? wr_q : (s == 3'b010 && !wn);
    endtask

    // suspend one edge, by the qualifier or by the clock enable
    task automatic hold(input logic by_en);
        @(posedge clk);
        clock_qualify_n <= ~by_en;
        clk_en          <= ~by_en;
    endtask

    // output enable changes just after an edge like every other pin
    task automatic set_oe(input logic v);
        @(posedge clk);
        out_enable_n <= v;
    endtask
endmodule

// ===== sim/fsp_sram_port_tb_top.sv
// self-checking bench for the flow-through memory port
// assumes the controller model owns every command and data input
`timescale 1ns/100ps
module fsp_sram_port_tb_top
    import fsp_pkg::*;
;
    localparam logic [2:0]        SEL = 3'b010;
    localparam logic [ADDR_W-1:0] A0  = 21'h1A_BCD5;
    localparam logic [ADDR_W-1:0] G   = 21'h0F_FFFC;
    localparam logic [DATA_W-1:0] D1  = 48'h1234_5678_9ABC;
    localparam logic [DATA_W-1:0] D2  = 48'hFEDC_BA98_7654;
    localparam logic [DATA_W-1:0] M   = 48'h00FF_00FF_00FF;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              qn, en, wn, adv, ilv, oe_n, dq_oe;
    logic [2:0]        sel;
    logic [LANES-1:0]  bl;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] dq_in, dq_out;
    int                mismatches = 0;
    int                check_count = 0;

    always #5 clk = ~clk;

    fsp_ctrl_model ctrl (.clk(clk), .clock_qualify_n(qn), .clk_en(en), .sel(sel), .write_n(wn),
        .byte_lane_write_n(bl), .advance_or_load(adv), .burst_interleave(ilv), .addr(a),
        .out_enable_n(oe_n), .dq_in(dq_in));
    fsp_sram_port DUT (.clk(clk), .rst_b(rst_b), .clk_en(en), .clock_qualify_n(qn),
        .select_low_a_n(sel[2]), .select_high(sel[1]), .select_low_b_n(sel[0]), .write_n(wn),
        .byte_lane_write_n(bl), .advance_or_load(adv), .burst_interleave(ilv), .addr(a),
        .out_enable_n(oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one load beat, then let the edge that took the previous beat settle
    task automatic ld(input logic w, input logic [LANES-1:0] m, input logic [ADDR_W-1:0] ad,
                      input logic [DATA_W-1:0] d);
        ctrl.beat(SEL, w, m, 1'b0, 1'b0, ad, d);
        #1;
    endtask

    task automatic step(input logic [2:0] s, input logic il);
        ctrl.beat(s, 1'b1, 6'h3F, 1'b1, il, '0, '0);
        #1;
    endtask

    task automatic t_write_read();
        ld(1'b0, 6'h00, A0, '0);
        ld(1'b1, 6'h3F, A0, D1);
        check(48'(dq_oe), 48'h0);
        ld(1'b0, 6'h2A, A0, '0);
        check(dq_out, D1);
        check(48'(dq_oe), 48'h1);
        ld(1'b1, 6'h3F, A0, D2);
        ctrl.beat(3'b110, 1'b1, 6'h3F, 1'b0, 1'b0, '0, '0);
        #1;
        check(dq_out, (D2 & M) | (D1 & ~M));
        $display("t_write_read done");
    endtask

    task automatic t_burst();
        logic [1:0] b;
        logic [1:0] w;
        for (int i = 0; i < 4; i++) ld(1'b0, 6'h00, G + 21'(i), D1 + 48'(i) - 48'h1);
        for (int m = 0; m < 2; m++) begin
            b = m ? 2'h1 : 2'h2;
            ctrl.beat(SEL, 1'b1, 6'h3F, 1'b0, 1'(m), G + 21'(b), D1 + 48'h3);
            for (int k = 0; k < 6; k++) begin
                step(SEL, 1'(m));
                w = m ? b ^ 2'(k) : b + 2'(k);
                check(dq_out, D1 + 48'(w));
            end
        end
        // qualifier high, then clock enable low: both edges are ignored
        ctrl.hold(1'b0);
        ctrl.hold(1'b1);
        step(SEL, 1'b1);
        check(dq_out, D1 + 48'h3);
        check(48'(dq_oe), 48'h1);
        step(SEL, 1'b1);
        check(dq_out, D1 + 48'h2);
        $display("t_burst done");
    endtask

    task automatic t_deselect();
        logic [2:0] s [3] = '{3'b110, 3'b000, 3'b011};
        for (int j = 0; j < 3; j++) begin
            ctrl.beat(s[j], 1'b1, 6'h3F, 1'b0, 1'b0, A0, '0);
            ld(1'b1, 6'h3F, A0, '0);
            check(48'(dq_oe), 48'h0);
            step(SEL, 1'b0);
            check(48'(dq_oe), 48'h0);
            check(dq_out, (D2 & M) | (D1 & ~M));
            ctrl.beat(3'b110, 1'b1, 6'h3F, 1'b0, 1'b0, '0, '0);
            #1;
            check(48'(dq_oe), 48'h1);
        end
        // reopen a read burst so only the output enable can float the pins
        ld(1'b1, 6'h3F, A0, '0);
        step(SEL, 1'b0);
        ctrl.set_oe(1'b1);
        #1;
        check(48'(dq_oe), 48'h0);
        ctrl.set_oe(1'b0);
        #1;
        check(48'(dq_oe), 48'h1);
        $display("t_deselect done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_write_read();
        t_burst();
        t_deselect();
        print_verdict();
    end

    // hang guard, far beyond the roughly 55 cycles the run needs
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule
